//--- pkg/fci_pkg.sv
package fci_pkg;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_IDENT = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0] CMD_BUFFER_PROGRAM = 8'he8;
    localparam logic [7:0] CMD_FACTORY_SETUP = 8'h80;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam int STATUS_READY_BIT = 7;
    localparam int STATUS_ERASE_SUSP_BIT = 6;
    localparam int STATUS_ERASE_ERR_BIT = 5;
    localparam int STATUS_PROG_ERR_BIT = 4;
    localparam int STATUS_PROG_SUSP_BIT = 2;
    localparam logic [7:0] STATUS_ERROR_MASK = 8'h3a;
    localparam int BUFFER_WORDS = 32;

    typedef enum logic [3:0]
    {
        FCI_RD_ARRAY = 4'h1,
        FCI_RD_STATUS = 4'h2,
        FCI_RD_IDENT = 4'h4,
        FCI_RD_QUERY = 4'h8
    } fci_read_t;

    typedef enum logic [9:0]
    {
        FCI_IDLE = 10'h001,
        FCI_PROG_SETUP = 10'h002,
        FCI_BUF_COUNT = 10'h004,
        FCI_BUF_DATA = 10'h008,
        FCI_BUF_CONFIRM = 10'h010,
        FCI_FACT_SETUP = 10'h020,
        FCI_ERASE_SETUP = 10'h040,
        FCI_BUSY = 10'h080,
        FCI_FACTORY = 10'h100,
        FCI_SUSPENDED = 10'h200
    } fci_state_t;

    typedef enum logic [2:0]
    {
        FCI_OP_NONE = 3'h0,
        FCI_OP_WORD = 3'h1,
        FCI_OP_BUFFER = 3'h2,
        FCI_OP_ERASE = 3'h3,
        FCI_OP_FACTORY = 3'h4
    } fci_op_t;

    typedef struct packed
    {
        fci_state_t state;
        fci_read_t read_state;
        fci_op_t op;
        logic [7:0] status_byte;
        logic [5:0] words_left;
        logic [22:0] addr;
        logic [15:0] data;
        logic start;
        logic suspend_req;
        logic resume_req;
        logic buf_write;
        logic [4:0] buf_index;
        logic busy;
    } fci_regs_t;
endpackage

//--- hw/fci_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - byte 0xff selects array read, full 16-bit data.
// - byte 0x70 selects status read, status on low byte.
// - issuing program or erase switches to status read automatically.
// - byte 0x90 selects identifier read, 16-bit data.
// - byte 0x98 selects query read, low byte.
// - engine only sets error bits; byte 0x50 clears them.
// - after 0x40 the next write latches address, data and starts programming.
// - during program only status read and suspend are accepted.
// - byte 0x10 behaves exactly like 0x40.
// - 0xe8 loads host-chosen word count, at most 32, into buffer.
// - confirm 0xd0 after buffer load starts copying buffer to array.
// - 0x80 arms factory mode awaiting 0xd0; then everything else ignored.
// - 0xd0 after factory setup latches address and data.
// - erase setup not followed by 0xd0 sets bits 4 and 5, status read.
// - 0xd0 after erase setup latches address and erases the block.
// - during erase only status read and suspend are accepted.
// - 0xb0 suspends; sets bit 2 or 6 with ready bit 7.
// - suspension persists until reset or resume.
// - 0xd0 while suspended resumes the operation.
// - after reset: array read, status byte 0x80.
module fci_decoder
    import fci_pkg::*;
#(
    parameter int ADDR_W = 23,
    parameter int DATA_W = 16
)
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic write_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic engine_done_in,
    input wire logic engine_suspended_in,
    input wire logic engine_prog_err_in,
    input wire logic engine_erase_err_in,
    output logic [3:0] read_state_out,
    output logic [7:0] status_byte_out,
    output logic [2:0] op_out,
    output logic start_out,
    output logic suspend_out,
    output logic resume_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out,
    output logic buf_write_out,
    output logic [4:0] buf_index_out,
    output logic factory_program_mode_out,
    output logic busy_out
);
    fci_regs_t r;
    fci_regs_t next_r;
    logic [7:0] cmd;

    assign cmd = data_in[7:0];

    always_comb
    begin
        next_r = r;
        next_r.start = 1'b0;
        next_r.suspend_req = 1'b0;
        next_r.resume_req = 1'b0;
        next_r.buf_write = 1'b0;
        // engine errors only ever set bits; clearing is a command's job
        if (engine_prog_err_in)
        begin
            next_r.status_byte[STATUS_PROG_ERR_BIT] = 1'b1;
        end
        if (engine_erase_err_in)
        begin
            next_r.status_byte[STATUS_ERASE_ERR_BIT] = 1'b1;
        end
        case (r.state)
            FCI_BUSY:
            begin
                if (engine_done_in)
                begin
                    next_r.state = FCI_IDLE;
                    next_r.status_byte[STATUS_READY_BIT] = 1'b1;
                    next_r.op = FCI_OP_NONE;
                end
                else if (engine_suspended_in)
                begin
                    next_r.state = FCI_SUSPENDED;
                    next_r.status_byte[STATUS_READY_BIT] = 1'b1;
                    if (r.op == FCI_OP_ERASE)
                    begin
                        next_r.status_byte[STATUS_ERASE_SUSP_BIT] = 1'b1;
                    end
                    else
                    begin
                        next_r.status_byte[STATUS_PROG_SUSP_BIT] = 1'b1;
                    end
                end
                else if (write_in)
                begin
                    // only status read and suspend are honoured
                    if (cmd == CMD_READ_STATUS)
                    begin
                        next_r.read_state = FCI_RD_STATUS;
                    end
                    else if (cmd == CMD_SUSPEND)
                    begin
                        next_r.suspend_req = 1'b1;
                    end
                end
            end
            FCI_FACTORY:
            begin
                // factory mode deaf to commands until the engine finishes
                if (engine_done_in)
                begin
                    next_r.state = FCI_IDLE;
                    next_r.op = FCI_OP_NONE;
                    next_r.status_byte[STATUS_READY_BIT] = 1'b1;
                end
            end
            FCI_PROG_SETUP:
            begin
                if (write_in)
                begin
                    next_r.addr = addr_in;
                    next_r.data = data_in;
                    next_r.op = FCI_OP_WORD;
                    next_r.start = 1'b1;
                    next_r.state = FCI_BUSY;
                    next_r.status_byte[STATUS_READY_BIT] = 1'b0;
                    next_r.read_state = FCI_RD_STATUS;
                end
            end
            FCI_BUF_COUNT:
            begin
                if (write_in)
                begin
                    // host owns the limit; a larger count is clipped to the buffer
                    if (data_in[4:0] == 5'h1f || data_in[15:5] != '0)
                    begin
                        next_r.words_left = 6'(BUFFER_WORDS);
                    end
                    else
                    begin
                        next_r.words_left = {1'b0, data_in[4:0]} + 6'h01;
                    end
                    // starts one before word 0 so the index port names the word just written
                    next_r.buf_index = 5'h1f;
                    next_r.state = FCI_BUF_DATA;
                end
            end
            FCI_BUF_DATA:
            begin
                if (write_in)
                begin
                    next_r.buf_write = 1'b1;
                    // the first word fixes the base address
                    if (r.buf_index == 5'h1f)
                    begin
                        next_r.addr = addr_in;
                    end
                    next_r.data = data_in;
                    next_r.buf_index = r.buf_index + 5'h01;
                    next_r.words_left = r.words_left - 6'h01;
                    if (r.words_left == 6'h01)
                    begin
                        next_r.state = FCI_BUF_CONFIRM;
                    end
                end
            end
            FCI_BUF_CONFIRM:
            begin
                if (write_in)
                begin
                    if (cmd == CMD_CONFIRM)
                    begin
                        next_r.op = FCI_OP_BUFFER;
                        next_r.start = 1'b1;
                        next_r.state = FCI_BUSY;
                        next_r.status_byte[STATUS_READY_BIT] = 1'b0;
                    end
                    else
                    begin
                        next_r.status_byte[STATUS_PROG_ERR_BIT] = 1'b1;
                        next_r.status_byte[STATUS_ERASE_ERR_BIT] = 1'b1;
                        next_r.state = FCI_IDLE;
                    end
                    next_r.read_state = FCI_RD_STATUS;
                end
            end
            FCI_FACT_SETUP:
            begin
                if (write_in)
                begin
                    if (cmd == CMD_CONFIRM)
                    begin
                        next_r.addr = addr_in;
                        next_r.data = data_in;
                        next_r.op = FCI_OP_FACTORY;
                        next_r.start = 1'b1;
                        next_r.state = FCI_FACTORY;
                        next_r.status_byte[STATUS_READY_BIT] = 1'b0;
                    end
                    else
                    begin
                        next_r.status_byte[STATUS_PROG_ERR_BIT] = 1'b1;
                        next_r.status_byte[STATUS_ERASE_ERR_BIT] = 1'b1;
                        next_r.state = FCI_IDLE;
                    end
                    next_r.read_state = FCI_RD_STATUS;
                end
            end
            FCI_ERASE_SETUP:
            begin
                if (write_in)
                begin
                    if (cmd == CMD_CONFIRM)
                    begin
                        next_r.addr = addr_in;
                        next_r.op = FCI_OP_ERASE;
                        next_r.start = 1'b1;
                        next_r.state = FCI_BUSY;
                        next_r.status_byte[STATUS_READY_BIT] = 1'b0;
                    end
                    else
                    begin
                        next_r.status_byte[STATUS_PROG_ERR_BIT] = 1'b1;
                        next_r.status_byte[STATUS_ERASE_ERR_BIT] = 1'b1;
                        next_r.state = FCI_IDLE;
                    end
                    next_r.read_state = FCI_RD_STATUS;
                end
            end
            FCI_IDLE, FCI_SUSPENDED:
            begin
                if (write_in)
                begin
                    case (cmd)
                        CMD_READ_ARRAY: next_r.read_state = FCI_RD_ARRAY;
                        CMD_READ_STATUS: next_r.read_state = FCI_RD_STATUS;
                        CMD_READ_IDENT: next_r.read_state = FCI_RD_IDENT;
                        CMD_READ_QUERY: next_r.read_state = FCI_RD_QUERY;
                        CMD_CLEAR_STATUS:
                        begin
                            next_r.status_byte = r.status_byte & ~STATUS_ERROR_MASK;
                            // a same-cycle engine error still lands
                            if (engine_prog_err_in)
                            begin
                                next_r.status_byte[STATUS_PROG_ERR_BIT] = 1'b1;
                            end
                            if (engine_erase_err_in)
                            begin
                                next_r.status_byte[STATUS_ERASE_ERR_BIT] = 1'b1;
                            end
                        end
                        // a new setup while suspended would strand the held operation
                        CMD_PROGRAM, CMD_PROGRAM_ALT:
                        begin
                            if (r.state == FCI_IDLE)
                            begin
                                next_r.state = FCI_PROG_SETUP;
                            end
                        end
                        CMD_BUFFER_PROGRAM:
                        begin
                            if (r.state == FCI_IDLE)
                            begin
                                next_r.state = FCI_BUF_COUNT;
                            end
                        end
                        CMD_ERASE_SETUP:
                        begin
                            if (r.state == FCI_IDLE)
                            begin
                                next_r.state = FCI_ERASE_SETUP;
                            end
                        end
                        CMD_FACTORY_SETUP:
                        begin
                            if (r.state == FCI_IDLE)
                            begin
                                next_r.state = FCI_FACT_SETUP;
                            end
                        end
                        CMD_CONFIRM:
                        begin
                            // no setup pending: 0xd0 means resume
                            if (r.state == FCI_SUSPENDED)
                            begin
                                next_r.resume_req = 1'b1;
                                next_r.state = FCI_BUSY;
                                next_r.status_byte[STATUS_READY_BIT] = 1'b0;
                                next_r.status_byte[STATUS_PROG_SUSP_BIT] = 1'b0;
                                next_r.status_byte[STATUS_ERASE_SUSP_BIT] = 1'b0;
                                next_r.read_state = FCI_RD_STATUS;
                            end
                        end
                        default: next_r.state = r.state;
                    endcase
                end
                // suspended state is held with nothing but resume or reset
            end
            default: next_r.state = FCI_IDLE;
        endcase
        // registered so the busy pin is a flop, not a decode of two state bits
        // factory mode counts as busy as well
        case (next_r.state)
            FCI_BUSY, FCI_FACTORY: next_r.busy = 1'b1;
            default: next_r.busy = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            r <= '0;
            r.state <= FCI_IDLE;
            r.read_state <= FCI_RD_ARRAY;
            r.op <= FCI_OP_NONE;
            r.status_byte <= STATUS_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign read_state_out = r.read_state;
    assign status_byte_out = r.status_byte;
    assign op_out = r.op;
    assign start_out = r.start;
    assign suspend_out = r.suspend_req;
    assign resume_out = r.resume_req;
    assign addr_out = r.addr;
    assign data_out = r.data;
    assign buf_write_out = r.buf_write;
    assign buf_index_out = r.buf_index;
    // state bits are flops; compare is a single-bit select in one-hot
    assign factory_program_mode_out = r.state[8];
    assign busy_out = r.busy;
endmodule

//--- verification/fci_decoder_assertions.sv
`timescale 1ns/1ps
module fci_decoder_assertions
    import fci_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic write_in,
    input wire logic [15:0] data_in,
    input wire logic engine_done_in,
    input wire logic engine_suspended_in,
    input wire logic engine_prog_err_in,
    input wire logic engine_erase_err_in,
    input wire logic [3:0] read_state_out,
    input wire logic [7:0] status_byte_out,
    input wire logic [2:0] op_out,
    input wire logic start_out,
    input wire logic resume_out,
    input wire logic factory_program_mode_out,
    input wire logic busy_out
);
    logic [7:0] prv;
    logic [7:0] prv2;
    logic ctx;
    logic free;
    // context guessed from the last two bytes; buffer words that look like commands would fool it
    function automatic logic plain(input logic [7:0] b);
        return b == CMD_READ_ARRAY || b == CMD_READ_STATUS || b == CMD_READ_IDENT || b == CMD_READ_QUERY
            || b == CMD_CLEAR_STATUS;
    endfunction
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            prv <= 8'hff;
            prv2 <= 8'hff;
        end
        else if (write_in)
        begin
            prv <= data_in[7:0];
            prv2 <= prv;
        end
    end
    assign ctx = !busy_out && !factory_program_mode_out && plain(prv2);
    assign free = write_in && ctx && plain(prv);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);
    a_read_array: assert property (free && data_in[7:0] == CMD_READ_ARRAY |=> read_state_out == 4'h1)
        else $error("array read not selected");
    a_read_status: assert property (free && data_in[7:0] == CMD_READ_STATUS |=> read_state_out == 4'h2)
        else $error("status read not selected");
    a_read_ident: assert property (free && data_in[7:0] == CMD_READ_IDENT |=> read_state_out == 4'h4)
        else $error("identifier read not selected");
    a_read_query: assert property (free && data_in[7:0] == CMD_READ_QUERY |=> read_state_out == 4'h8)
        else $error("query read not selected");
    a_clear_err: assert property (free && data_in[7:0] == CMD_CLEAR_STATUS && !engine_prog_err_in
        && !engine_erase_err_in |=> (status_byte_out & STATUS_ERROR_MASK) == 8'h00) else $error("errors not cleared");
    a_err_set: assert property (engine_prog_err_in |=> status_byte_out[4])
        else $error("program error bit not set");
    a_word_start: assert property (write_in && ctx && (prv == CMD_PROGRAM || prv == CMD_PROGRAM_ALT)
        |=> start_out && op_out == 3'h1 && read_state_out == 4'h2 && busy_out) else $error("word program not started");
    a_busy_deaf: assert property (busy_out && write_in && data_in[7:0] != CMD_READ_STATUS
        && data_in[7:0] != CMD_SUSPEND && !engine_done_in |=> $stable(read_state_out) && !start_out)
        else $error("command taken while busy");
    a_erase_bad: assert property (write_in && ctx && prv == CMD_ERASE_SETUP && data_in[7:0] != CMD_CONFIRM
        |=> status_byte_out[5:4] == 2'b11 && read_state_out == 4'h2) else $error("sequence error not flagged");
    a_erase_go: assert property (write_in && ctx && prv == CMD_ERASE_SETUP && data_in[7:0] == CMD_CONFIRM
        |=> start_out && op_out == 3'h3) else $error("erase not started");
    a_susp_flag: assert property (engine_suspended_in && op_out == 3'h3 |=> status_byte_out[7:6] == 2'b11)
        else $error("erase suspend not flagged");
    a_susp_hold: assert property (status_byte_out[6] && !write_in && !engine_done_in |=> status_byte_out[6])
        else $error("suspension dropped");
    a_fact_deaf: assert property (factory_program_mode_out && !engine_done_in
        |=> factory_program_mode_out && op_out == 3'h4 && !resume_out) else $error("factory mode left");
    a_reset_state: assert property (disable iff (1'b0) !arst_n_in |-> read_state_out == 4'h1
        && status_byte_out == 8'h80) else $error("reset state wrong");
endmodule
bind fci_decoder fci_decoder_assertions i_fci_decoder_assertions (.mclk_in, .arst_n_in, .write_in, .data_in,
    .engine_done_in, .engine_suspended_in, .engine_prog_err_in, .engine_erase_err_in, .read_state_out,
    .status_byte_out, .op_out, .start_out, .resume_out, .factory_program_mode_out, .busy_out);

//--- verification/fci_engine_model.sv
`timescale 1ns/1ps
module fci_engine_model
#(
    parameter int RUN = 12
)
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic start_in,
    input wire logic suspend_in,
    input wire logic resume_in,
    input wire logic fail_in,
    output logic done_out,
    output logic suspended_out,
    output logic err_out
);
    int left;
    logic halted;
    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            left <= 0;
            halted <= 1'b0;
            done_out <= 1'b0;
            suspended_out <= 1'b0;
            err_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            suspended_out <= 1'b0;
            err_out <= 1'b0;
            if (start_in)
                left <= RUN;
            else if (suspend_in && left > 0)
            begin
                halted <= 1'b1;
                suspended_out <= 1'b1;
            end
            else if (resume_in)
                halted <= 1'b0;
            else if (left > 0 && !halted)
            begin
                left <= left - 1;
                done_out <= left == 1;
                err_out <= left == 1 && fail_in;
            end
        end
    end
endmodule

//--- verification/test_flash_command_interpreter.sv
`timescale 1ns/1ps
module test_flash_command_interpreter;
    import fci_pkg::*;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b1;
    logic write_in = 1'b0;
    logic [22:0] addr_in = 23'h0;
    logic [15:0] data_in = 16'h0;
    logic fail = 1'b0;
    logic done, susp, err, start, suspend, resume, bufw, fpm, busy;
    logic [3:0] rs;
    logic [7:0] st;
    logic [2:0] op;
    logic [22:0] addr_q;
    logic [15:0] data_q;
    logic [4:0] bidx;
    logic [7:0] rc [4] = '{8'h70, 8'h90, 8'h98, 8'hff};
    logic [3:0] rx [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
    int err_total = 0;
    int tests_run = 0;
    fci_decoder i_fci_decoder (.mclk_in, .arst_n_in, .write_in, .addr_in, .data_in, .engine_done_in(done),
        .engine_suspended_in(susp), .engine_prog_err_in(err && op != 3'h3),
        .engine_erase_err_in(err && op == 3'h3), .read_state_out(rs),
        .status_byte_out(st), .op_out(op), .start_out(start), .suspend_out(suspend), .resume_out(resume),
        .addr_out(addr_q), .data_out(data_q), .buf_write_out(bufw), .buf_index_out(bidx),
        .factory_program_mode_out(fpm), .busy_out(busy));
    fci_engine_model i_fci_engine_model (.mclk_in, .arst_n_in, .start_in(start), .suspend_in(suspend),
        .resume_in(resume), .fail_in(fail), .done_out(done), .suspended_out(susp), .err_out(err));
    initial
        forever #10 mclk_in = ~mclk_in;
    task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] d, input logic [22:0] a = 23'h0);
        @(posedge mclk_in);
        #1;
        write_in = 1'b1;
        data_in = d;
        addr_in = a;
    endtask
    task automatic gap(input int n);
        repeat (n)
        begin
            @(posedge mclk_in);
            #1;
            write_in = 1'b0;
        end
    endtask
    // waits for the engine's finish, or its suspend when a suspend flag is expected
    task automatic finish_op(input logic [7:0] exp);
        int k;
        k = 0;
        while (((exp[6] || exp[2]) ? susp : done) !== 1'b1 && k < 300)
        begin
            gap(1);
            k++;
        end
        chk("engine wait", 1'b0, k == 300);
        gap(1);
        chk("status", exp, st);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        // driven low after time zero so the reset edge is seen
        #1;
        arst_n_in = 1'b0;
        repeat (5) @(posedge mclk_in);
        #1;
        arst_n_in = 1'b1;
        chk("read state", 4'h1, rs);
        chk("status", 8'h80, st);
        for (int i = 0; i < 4; i++)
        begin
            wr({8'h00, rc[i]});
            gap(1);
            chk("read state", rx[i], rs);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr({8'h00, i == 0 ? CMD_PROGRAM : CMD_PROGRAM_ALT}, 23'h5);
            wr(16'h1234 ^ 16'(i), 23'h5);
            gap(1);
            chk("start", 1'b1, start);
            chk("op", 3'h1, op);
            chk("read state", 4'h2, rs);
            chk("data", 16'h1234 ^ 16'(i), data_q);
            chk("addr", 23'h5, addr_q);
            chk("busy", 1'b1, busy);
            wr(16'h00ff);
            gap(1);
            chk("read state", 4'h2, rs);
            finish_op(8'h80);
            chk("busy", 1'b0, busy);
        end
        wr(16'h00ff);
        wr(16'h0040);
        wr(16'hbeef, 23'h9);
        wr(16'h00b0, 23'h7abc);
        gap(1);
        chk("suspend", 1'b1, suspend);
        finish_op(8'h84);
        gap(10);
        chk("status", 8'h84, st);
        wr(16'h0020);
        wr(16'h00d0, 23'h1);
        gap(1);
        chk("resume", 1'b1, resume);
        finish_op(8'h80);
        wr(16'h0070);
        wr(16'h0020, 23'h40000);
        wr(16'h00d0, 23'h40000);
        gap(1);
        chk("op", 3'h3, op);
        chk("start", 1'b1, start);
        wr(16'h0050);
        wr(16'h00b0);
        finish_op(8'hc0);
        wr(16'h00d0);
        gap(1);
        chk("resume", 1'b1, resume);
        finish_op(8'h80);
        wr(16'h0070);
        wr(16'h0020);
        wr(16'h00ff);
        gap(1);
        chk("status", 8'hb0, st);
        chk("read state", 4'h2, rs);
        wr(16'h0070);
        wr(16'h0050);
        gap(1);
        chk("status", 8'h80, st);
        fail = 1'b1;
        wr(16'h0040);
        wr(16'h5a5a);
        finish_op(8'h90);
        chk("error bit", 1'b1, st[4]);
        fail = 1'b0;
        wr(16'h0050);
        gap(1);
        chk("status", 8'h80, st);
        wr(16'h00e8, 23'h100);
        wr(16'h0002, 23'h100);
        for (int i = 1; i < 4; i++)
        begin
            wr(16'ha000 | 16'(i), 23'h100);
            gap(1);
            chk("buffer write", 1'b1, bufw);
            chk("buffer index", 23'(i - 1), bidx);
        end
        wr(16'h00d0, 23'h100);
        gap(1);
        chk("op", 3'h2, op);
        chk("start", 1'b1, start);
        chk("data", 16'ha003, data_q);
        chk("addr", 23'h100, addr_q);
        finish_op(8'h80);
        wr(16'h0080, 23'h200);
        wr(16'h00d0, 23'h200);
        gap(1);
        chk("factory", 1'b1, fpm);
        chk("addr", 23'h200, addr_q);
        wr(16'h00ff);
        wr(16'h0020);
        gap(1);
        chk("factory", 1'b1, fpm);
        chk("op", 3'h4, op);
        chk("read state", 4'h2, rs);
        summarize();
    end
    initial
    begin
        repeat (4000) @(posedge mclk_in);
        err_total++;
        summarize();
    end
endmodule
